//--- flq_regs.svh
// Register offsets, reset values and timing counts of the fault latch block.
// Assumes a 32-bit APB bus with one aligned word per register.
`ifndef FLQ_REGS_SVH
`define FLQ_REGS_SVH
`define FLQ_CTRL_OFS      12'h000
`define FLQ_STATUS_OFS    12'h004
`define FLQ_ENMASK_OFS    12'h008
`define FLQ_TIMER_OFS     12'h00C
`define FLQ_MARKER_OFS    12'h010
`define FLQ_IRQ_STAT_OFS  12'h014
`define FLQ_IRQ_MASK_OFS  12'h018
`define FLQ_SNAP_STAT_OFS 12'h020
`define FLQ_SNAP_ALRM_OFS 12'h024
`define FLQ_SNAP_AMPS_OFS 12'h028
`define FLQ_SNAP_BUS_OFS  12'h02C
`define FLQ_SNAP_FREQ_OFS 12'h030
`define FLQ_QCODE_OFS     12'h040
`define FLQ_QTIME_OFS     12'h080
`define FLQ_CTRL_CLR_BIT  0
`define FLQ_CTRL_DEF_BIT  1
`define FLQ_CTRL_QCLR_BIT 2
`define FLQ_ENMASK_RST    16'hFFFF
`define FLQ_TICK_PS       64'h00000053D1AC1000
`define FLQ_CLK_PS        64'h0000000000000FA0
`endif

//--- flq_pkg.sv
// Types shared by the fault latch block.
// Assumes flq_regs.svh supplies the numeric constants.
package flq_pkg;
   typedef struct packed {
      logic [15:0] status1;
      logic [15:0] status2;
      logic [15:0] alarm1;
      logic [15:0] alarm2;
      logic [15:0] amps;
      logic [15:0] bus_volts;
      logic [15:0] freq;
   } flq_snap_t;
   typedef struct packed {
      logic        valid;
      logic [15:0] code;
      logic [31:0] stamp;
   } flq_entry_t;
   typedef enum logic [1:0] {
      FLQ_POWERUP = 2'b00,
      FLQ_RUN     = 2'b01,
      FLQ_FAULTED = 2'b11
   } flq_state_t;
endpackage : flq_pkg

//--- flq_fault_latch.sv
// Fault latch, snapshot and newest-first history queue with powered-time stamps.
// Assumes fault sources and drive conditions are synchronous to core_clk,
// the reset input pin is asynchronous, and retention is kept by the always-on domain.
//
// Functional notes
// - A trip sets faulted, kills the power output and starts coast to stop.
// - Trip stays latched until reset; a still present cause trips again.
// - A logged trip code goes into the newest queue slot.
// - One shared snapshot of drive conditions is overwritten at each logged trip.
// - Queue depth is four on the small variant, eight on the large.
// - Only trips taken while not already faulted are logged.
// - Logging shifts entries toward oldest and drops the oldest when full.
// - Each entry holds trip code and powered-time stamp at the trip.
// - Powered-time is a 32-bit wrapping counter, not writable by the user.
// - Each power-up copies the powered-time value into the marker.
// - One time count is about 0.36 s of powered time.
// - Reset input edge, clear write, peripheral, defaults or power cycle clear.
// - Fault reset leaves the history queue untouched.
// - A 16-bit enable mask gates configurable trips; cleared bits hide them.
// - Queue contents are retained across power cycles.
// - Each entry's code is readable; text lookup is up to the peripheral.
`timescale 1ns/1ns
`include "flq_regs.svh"
module flq_fault_latch
   import flq_pkg::*;
#(
   parameter int          DEPTH   = 8,
   parameter longint      TICK_CYC = (`FLQ_TICK_PS) / (`FLQ_CLK_PS),
   parameter logic [15:0] CFG_CODE_BASE = 16'h0100
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        power_up,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Fault sources
   input  wire logic        fixed_trip,
   input  wire logic [15:0] fixed_code,
   input  wire logic [15:0] cfg_trip,
   input  wire logic        reset_input,
   input  wire logic        periph_clear,
   // Drive conditions
   input  flq_snap_t        conditions,
   // Drive outputs
   output logic             faulted,
   output logic             output_enable,
   output logic             coast_stop,
   output logic             irq
);
   localparam int QW = (DEPTH > 4) ? 3 : 2;
   localparam longint TICKS = (TICK_CYC < 1) ? 1 : TICK_CYC;

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers
   logic [2:0] rst_in_sync;
   logic       rst_in_rise;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rst_in_sync <= 3'h0;
      end else begin
         rst_in_sync <= {rst_in_sync[1:0], reset_input};
      end
   end
   assign rst_in_rise = rst_in_sync[1] & ~rst_in_sync[2];

   a_pin_one_pulse: assert property (@(posedge core_clk) disable iff (reset)
      rst_in_rise |=> !rst_in_rise)
      else $error("pin reset edge longer than one cycle");

   ////////////////////////////////////////////////////////////////////////////
   // Registers written by software
   logic [15:0] enmask;
   logic [1:0]  irq_mask;
   logic        wr_acc;
   logic        rd_acc;
   logic        sw_clear;
   logic        sw_defaults;
   logic        sw_qclear;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign sw_clear    = wr_acc && paddr == `FLQ_CTRL_OFS && pwdata[`FLQ_CTRL_CLR_BIT];
   assign sw_defaults = wr_acc && paddr == `FLQ_CTRL_OFS && pwdata[`FLQ_CTRL_DEF_BIT];
   assign sw_qclear   = wr_acc && paddr == `FLQ_CTRL_OFS && pwdata[`FLQ_CTRL_QCLR_BIT];

   always_ff @(posedge core_clk) begin
      if (reset) begin
         enmask   <= `FLQ_ENMASK_RST;
         irq_mask <= 2'h0;
      end else if (sw_defaults) begin
         enmask   <= `FLQ_ENMASK_RST;
      end else if (wr_acc && paddr == `FLQ_ENMASK_OFS) begin
         enmask   <= pwdata[15:0];
      end else if (wr_acc && paddr == `FLQ_IRQ_MASK_OFS) begin
         irq_mask <= pwdata[1:0];
      end
   end

   a_defaults_mask: assert property (@(posedge core_clk) disable iff (reset)
      sw_defaults |=> enmask == `FLQ_ENMASK_RST)
      else $error("defaults did not restore the enable mask");

   a_mask_write: assert property (@(posedge core_clk) disable iff (reset)
      wr_acc && paddr == `FLQ_ENMASK_OFS |=> enmask == $past(pwdata[15:0]))
      else $error("enable mask write lost");

   ////////////////////////////////////////////////////////////////////////////
   // Powered-time counter and power-up marker
   // Retained count: neither reset nor power_up clears it, the initial value
   // stands for the stored count; only the prescaler restarts on reset
   logic [31:0] ptime = 32'h0;
   logic [31:0] marker;
   logic [63:0] tick_cnt;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tick_cnt <= 64'h0;
      end else if (tick_cnt >= 64'(TICKS - 1)) begin
         tick_cnt <= 64'h0;
         ptime    <= ptime + 32'h1;
      end else begin
         tick_cnt <= tick_cnt + 64'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (power_up) begin
         marker <= ptime;
      end
   end

   a_time_step: assert property (@(posedge core_clk) disable iff (reset)
      tick_cnt >= 64'(TICKS - 1) |=> ptime == $past(ptime) + 32'h1)
      else $error("powered time did not advance");

   a_time_hold: assert property (@(posedge core_clk) disable iff (reset)
      tick_cnt < 64'(TICKS - 1) |=> ptime == $past(ptime))
      else $error("powered time moved between counts");

   a_marker_copy: assert property (@(posedge core_clk) disable iff (reset)
      power_up |=> marker == $past(ptime))
      else $error("marker not copied at power-up");

   ////////////////////////////////////////////////////////////////////////////
   // Trip detection and latch
   logic [15:0] cfg_hit;
   logic        trip_now;
   logic [15:0] trip_code;
   logic        fault_reset;
   flq_state_t  state;
   logic        log_now;
   assign cfg_hit = cfg_trip & enmask;
   assign trip_now = fixed_trip | (|cfg_hit);
   assign fault_reset = rst_in_rise | sw_clear | periph_clear | sw_defaults | power_up;
   always_comb begin
      trip_code = fixed_code;
      if (!fixed_trip) begin
         for (int i = 15; i >= 0; i--) begin
            if (cfg_hit[i]) begin
               trip_code = CFG_CODE_BASE + 16'(i);
            end
         end
      end
   end
   assign log_now = trip_now && state == FLQ_RUN;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= FLQ_POWERUP;
      end else begin
         case (state)
            FLQ_POWERUP: state <= FLQ_RUN;
            FLQ_RUN: begin
               if (trip_now) begin
                  state <= FLQ_FAULTED;
               end
            end
            FLQ_FAULTED: begin
               if (fault_reset) begin
                  state <= FLQ_RUN;
               end
            end
            default: state <= FLQ_POWERUP;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         faulted       <= 1'b0;
         output_enable <= 1'b0;
         coast_stop    <= 1'b1;
      end else begin
         faulted       <= (state == FLQ_FAULTED) | log_now;
         output_enable <= (state == FLQ_RUN) & ~trip_now;
         coast_stop    <= (state != FLQ_RUN) | trip_now;
      end
   end

   a_trip_disables: assert property (@(posedge core_clk) disable iff (reset)
      state == FLQ_RUN && trip_now |=> !output_enable && coast_stop && faulted)
      else $error("trip did not disable output");

   a_latch_holds: assert property (@(posedge core_clk) disable iff (reset)
      state == FLQ_FAULTED && !fault_reset |=> state == FLQ_FAULTED)
      else $error("fault latch dropped without reset");

   a_mask_gate: assert property (@(posedge core_clk) disable iff (reset)
      state == FLQ_RUN && !fixed_trip && (cfg_trip & enmask) == 16'h0 |=> !faulted)
      else $error("masked trip took effect");

   a_faulted_off: assert property (@(posedge core_clk) disable iff (reset)
      faulted |-> !output_enable && coast_stop)
      else $error("output live while faulted");

   a_oe_run: assert property (@(posedge core_clk) disable iff (reset)
      state == FLQ_RUN && !trip_now |=> output_enable && !faulted)
      else $error("output not restored after fault reset");

   ////////////////////////////////////////////////////////////////////////////
   // Snapshot and history queue, held in retained storage
   flq_snap_t  snap;
   flq_entry_t queue [DEPTH];
   always_ff @(posedge core_clk) begin
      if (log_now) begin
         snap <= conditions;
      end
   end
   // Retained through reset and power cycles; only the queue clear empties it
   for (genvar g = 0; g < DEPTH; g++) begin : g_slot
      always_ff @(posedge core_clk) begin
         if (log_now) begin
            if (g == 0) begin
               queue[g] <= '{valid: 1'b1, code: trip_code, stamp: ptime};
            end else begin
               queue[g] <= queue[g-1];
            end
         end else if (sw_qclear) begin
            queue[g] <= '0;
         end
      end
   end

   a_snap_take: assert property (@(posedge core_clk) disable iff (reset)
      log_now |=> snap == $past(conditions))
      else $error("snapshot not captured");

   a_newest_code: assert property (@(posedge core_clk) disable iff (reset)
      log_now |=> queue[0].code == $past(trip_code) && queue[0].valid)
      else $error("newest slot missing trip code");

   a_fixed_wins: assert property (@(posedge core_clk) disable iff (reset)
      state == FLQ_RUN && fixed_trip |=> queue[0].code == $past(fixed_code))
      else $error("fixed trip code not logged first");

   a_stamp_taken: assert property (@(posedge core_clk) disable iff (reset)
      log_now |=> queue[0].stamp == $past(ptime))
      else $error("stamp not taken");

   a_shift_old: assert property (@(posedge core_clk) disable iff (reset)
      log_now |=> queue[1] == $past(queue[0]))
      else $error("queue did not shift");

   a_shift_last: assert property (@(posedge core_clk) disable iff (reset)
      log_now |=> queue[DEPTH-1] == $past(queue[DEPTH-2]))
      else $error("oldest slot did not shift");

   // While latched the queue may only change by an explicit clear
   a_no_relog: assert property (@(posedge core_clk) disable iff (reset)
      state == FLQ_FAULTED && !sw_qclear |=> queue[0] == $past(queue[0]))
      else $error("trip logged while faulted");

   a_qclear_empty: assert property (@(posedge core_clk) disable iff (reset)
      sw_qclear && !log_now |=> !queue[0].valid && !queue[DEPTH-1].valid)
      else $error("queue clear left entries");

   a_reset_keeps_q: assert property (@(posedge core_clk) disable iff (reset)
      fault_reset && !log_now && !sw_qclear |=> queue[0] == $past(queue[0]))
      else $error("fault reset touched queue");

   a_q_readonly: assert property (@(posedge core_clk) disable iff (reset)
      wr_acc && paddr == `FLQ_QCODE_OFS && !log_now |=> queue[0] == $past(queue[0]))
      else $error("queue entry written by software");

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: bit0 trip logged, bit1 trip logged into a full queue
   logic [1:0] irq_stat;
   logic [1:0] irq_set;
   logic       stat_read;
   logic [1:0] stat_keep;
   assign irq_set = {log_now & queue[DEPTH-1].valid, log_now};
   assign stat_read = rd_acc && paddr == `FLQ_IRQ_STAT_OFS;
   // A read clears only the bits it reported, so an event landing between
   // setup and access is not lost; prdata holds the reported word here
   assign stat_keep = stat_read ? (irq_stat & ~prdata[1:0]) : irq_stat;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_stat <= 2'h0;
         irq      <= 1'b0;
      end else begin
         irq_stat <= stat_keep | irq_set;
         irq      <= |((stat_keep | irq_set) & irq_mask);
      end
   end

   a_stat_sticky: assert property (@(posedge core_clk) disable iff (reset)
      irq_set[0] |=> irq_stat[0])
      else $error("logged trip not flagged");

   ////////////////////////////////////////////////////////////////////////////
   // APB read path, one wait-free access phase
   logic [31:0] next_prdata;
   logic        next_err;
   logic [QW-1:0] qidx;
   always_comb begin
      next_prdata = 32'h0;
      next_err    = 1'b0;
      qidx        = paddr[QW+1:2];
      case (paddr)
         `FLQ_CTRL_OFS:      next_prdata = 32'h0;
         `FLQ_STATUS_OFS:    next_prdata = {30'h0, output_enable, faulted};
         `FLQ_ENMASK_OFS:    next_prdata = {16'h0, enmask};
         `FLQ_TIMER_OFS:     next_prdata = ptime;
         `FLQ_MARKER_OFS:    next_prdata = marker;
         `FLQ_IRQ_STAT_OFS:  next_prdata = {30'h0, irq_stat};
         `FLQ_IRQ_MASK_OFS:  next_prdata = {30'h0, irq_mask};
         `FLQ_SNAP_STAT_OFS: next_prdata = {snap.status2, snap.status1};
         `FLQ_SNAP_ALRM_OFS: next_prdata = {snap.alarm2, snap.alarm1};
         `FLQ_SNAP_AMPS_OFS: next_prdata = {16'h0, snap.amps};
         `FLQ_SNAP_BUS_OFS:  next_prdata = {16'h0, snap.bus_volts};
         `FLQ_SNAP_FREQ_OFS: next_prdata = {16'h0, snap.freq};
         default: begin
            if (paddr >= `FLQ_QCODE_OFS && paddr < `FLQ_QCODE_OFS + 12'(4 * DEPTH)) begin
               next_prdata = {15'h0, queue[qidx].valid, queue[qidx].code};
               next_err    = pwrite;
            end else if (paddr >= `FLQ_QTIME_OFS
                         && paddr < `FLQ_QTIME_OFS + 12'(4 * DEPTH)) begin
               next_prdata = queue[qidx].stamp;
               next_err    = pwrite;
            end else begin
               next_err    = 1'b1;
            end
         end
      endcase
   end
   // Ready is registered so the access phase is exactly one cycle long
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         prdata  <= pwrite ? 32'h0 : next_prdata;
         pslverr <= psel & ~penable & next_err;
      end
   end

endmodule : flq_fault_latch

//--- flq_user_model.sv
// User-side model of the fault latch: a push button on the fault reset pin.
// Assumes push is a level from the bench and the pin idles low between pushes.
`timescale 1ns/1ns
module flq_user_model (
   // Clock of the bench
   input  wire logic core_clk,
   // Request from the bench
   input  wire logic push,
   // Pin into the block
   output logic      reset_input
);
   logic       push_d = 1'b0;
   logic [3:0] hold   = 4'h0;
   // Off-to-on edge held eight cycles, long enough to pass the two-stage synchroniser
   always @(posedge core_clk) begin
      push_d <= push;
      if (push && !push_d) begin
         hold <= 4'h8;
      end else if (hold != 4'h0) begin
         hold <= hold - 4'h1;
      end
   end
   assign reset_input = (hold != 4'h0);
endmodule : flq_user_model

//--- test_fault_latch_and_history_queue.sv
// Self-checking bench for the fault latch and history queue.
// Assumes a time tick of 4 cycles and a four-entry queue.
`timescale 1ns/1ns
`include "flq_regs.svh"
module test_fault_latch_and_history_queue;
   import flq_pkg::*;
   localparam int D = 4;
   logic        core_clk = 0, reset = 1, power_up = 0, push = 0;
   logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic        fixed_trip = 0, periph_clear = 0, reset_input;
   logic [15:0] fixed_code = 0, cfg_trip = 0;
   flq_snap_t   conditions = '0;
   logic        faulted, output_enable, coast_stop, irq;
   int          errors = 0, compares = 0;
   always #2 core_clk = ~core_clk;
   flq_fault_latch #(.DEPTH(D), .TICK_CYC(4)) u_dut (
      .core_clk(core_clk), .reset(reset), .power_up(power_up), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fixed_trip(fixed_trip),
      .fixed_code(fixed_code), .cfg_trip(cfg_trip), .reset_input(reset_input),
      .periph_clear(periph_clear), .conditions(conditions), .faulted(faulted),
      .output_enable(output_enable), .coast_stop(coast_stop), .irq(irq));
   flq_user_model u_user (.core_clk(core_clk), .push(push), .reset_input(reset_input));
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      compares++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   // Idle edge after each transfer so no strobe is driven twice in one step
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         report_and_stop();
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   task automatic rchk(string n, logic [11:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rdat);
   endtask : rchk
   ////////////////////////////////////////////////////////////
   task automatic s_regs;
      logic [31:0] t1;
      rchk("enmask", `FLQ_ENMASK_OFS, 32'h0000FFFF);
      rchk("status", `FLQ_STATUS_OFS, 32'h00000002);
      apb(1'b0, 12'h0FC, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rerr});
      apb(1'b1, `FLQ_QCODE_OFS, 32'h0001ABCD);
      chk("queue write err", 32'h1, {31'h0, rerr});
      for (int i = 0; i < D; i++)
         rchk("empty code", 12'(`FLQ_QCODE_OFS + 4 * i), 32'h0);
      apb(1'b0, `FLQ_TIMER_OFS, 32'h0);
      t1 = rdat;
      apb(1'b1, `FLQ_TIMER_OFS, 32'h0);
      tick(30);
      apb(1'b0, `FLQ_TIMER_OFS, 32'h0);
      chk("timer step", 32'h1, {31'h0, (rdat - t1 >= 8 && rdat - t1 <= 10)});
   endtask : s_regs
   task automatic s_trip;
      logic [31:0] t0;
      apb(1'b1, `FLQ_IRQ_MASK_OFS, 32'h1);
      conditions <= {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h55, 16'h66, 16'h77};
      apb(1'b0, `FLQ_TIMER_OFS, 32'h0);
      t0 = rdat;
      fixed_code <= 16'h0021;
      fixed_trip <= 1'b1;
      tick(3);
      chk("trip state", 32'h5, {29'h0, faulted, output_enable, coast_stop});
      chk("irq on trip", 32'h1, {31'h0, irq});
      rchk("code new", `FLQ_QCODE_OFS, 32'h00010021);
      rchk("snap status", `FLQ_SNAP_STAT_OFS, 32'h22221111);
      rchk("snap alarm", `FLQ_SNAP_ALRM_OFS, 32'h44443333);
      rchk("snap amps", `FLQ_SNAP_AMPS_OFS, 32'h55);
      rchk("snap bus", `FLQ_SNAP_BUS_OFS, 32'h66);
      rchk("snap freq", `FLQ_SNAP_FREQ_OFS, 32'h77);
      apb(1'b0, `FLQ_QTIME_OFS, 32'h0);
      chk("stamp", 32'h1, {31'h0, (rdat - t0 <= 1)});
      fixed_code <= 16'h0022;
      tick(3);
      rchk("code held", `FLQ_QCODE_OFS, 32'h00010021);
      rchk("irq status", `FLQ_IRQ_STAT_OFS, 32'h1);
      tick(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // Clear while the cause is still present must relatch and log again
      apb(1'b1, `FLQ_CTRL_OFS, 32'h1);
      tick(3);
      chk("relatch", 32'h1, {31'h0, faulted});
      rchk("code shifted new", `FLQ_QCODE_OFS, 32'h00010022);
      rchk("code shifted old", `FLQ_QCODE_OFS + 12'h4, 32'h00010021);
      fixed_trip <= 1'b0;
      apb(1'b1, `FLQ_CTRL_OFS, 32'h1);
      tick(3);
      chk("cleared", 32'h1, {30'h0, faulted, output_enable});
   endtask : s_trip
   task automatic s_mask;
      apb(1'b1, `FLQ_ENMASK_OFS, 32'hFFFD);
      cfg_trip <= 16'h0002;
      tick(4);
      chk("masked trip", 32'h0, {31'h0, faulted});
      rchk("masked hidden", `FLQ_QCODE_OFS, 32'h00010022);
      apb(1'b1, `FLQ_ENMASK_OFS, 32'hFFFF);
      tick(2);
      chk("enabled trip", 32'h1, {31'h0, faulted});
      rchk("cfg code", `FLQ_QCODE_OFS, 32'h00010101);
      cfg_trip <= 16'h0;
      push     <= 1'b1;
      tick(14);
      chk("pin reset", 32'h0, {31'h0, faulted});
      push     <= 1'b0;
   endtask : s_mask
   task automatic s_fill;
      apb(1'b1, `FLQ_IRQ_MASK_OFS, 32'h0);
      apb(1'b0, `FLQ_IRQ_STAT_OFS, 32'h0);
      for (int k = 0; k <= D; k++) begin
         fixed_code   <= 16'h0030 + 16'(k);
         fixed_trip   <= 1'b1;
         tick(2);
         fixed_trip   <= 1'b0;
         periph_clear <= 1'b1;
         tick(1);
         periph_clear <= 1'b0;
         tick(2);
      end
      chk("irq masked", 32'h0, {31'h0, irq});
      rchk("full flag", `FLQ_IRQ_STAT_OFS, 32'h3);
      // Block reset must not touch the retained queue
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      tick(2);
      for (int i = 0; i < D; i++)
         rchk("queue order", 12'(`FLQ_QCODE_OFS + 4 * i), 32'h00010030 + 32'(D - i));
   endtask : s_fill
   task automatic s_power;
      logic [31:0] m;
      apb(1'b1, `FLQ_CTRL_OFS, 32'h4);
      for (int i = 0; i < D; i++)
         rchk("cleared code", 12'(`FLQ_QCODE_OFS + 4 * i), 32'h0);
      apb(1'b1, `FLQ_ENMASK_OFS, 32'h0);
      fixed_trip <= 1'b1;
      tick(2);
      fixed_trip <= 1'b0;
      apb(1'b1, `FLQ_CTRL_OFS, 32'h2);
      tick(2);
      chk("default clear", 32'h0, {31'h0, faulted});
      rchk("default mask", `FLQ_ENMASK_OFS, 32'hFFFF);
      fixed_trip <= 1'b1;
      tick(2);
      fixed_trip <= 1'b0;
      power_up   <= 1'b1;
      tick(1);
      power_up   <= 1'b0;
      tick(2);
      chk("power clear", 32'h0, {31'h0, faulted});
      apb(1'b0, `FLQ_MARKER_OFS, 32'h0);
      m = rdat;
      apb(1'b0, `FLQ_TIMER_OFS, 32'h0);
      chk("marker", 32'h1, {31'h0, (rdat - m <= 3)});
   endtask : s_power
   ////////////////////////////////////////////////////////////
   initial begin
      tick(5);
      reset    <= 1'b0;
      tick(2);
      // Queue clear first: the retained queue is unknown until then
      apb(1'b1, `FLQ_CTRL_OFS, 32'h4);
      power_up <= 1'b1;
      tick(1);
      power_up <= 1'b0;
      s_regs();
      s_trip();
      s_mask();
      s_fill();
      s_power();
      report_and_stop();
   end
endmodule : test_fault_latch_and_history_queue
